// file: core/gpc_port.sv
`timescale 1ns/1ps
//==========================================================================
// eight-pin general purpose port with software register file
module gpc_port (
  input  wire logic                                   clk,
  input  wire logic                                   nrst,
  input  wire logic [gpc_pkg::ADDR_W-1:0]             addr,
  input  wire logic [gpc_pkg::DATA_W-1:0]             wdata,
  input  wire logic                                   wr,
  input  wire logic                                   rd,
  output logic      [gpc_pkg::DATA_W-1:0]             rdata,
  input  wire logic [gpc_pkg::PIN_W-1:0]              pad_in,
  output logic      [gpc_pkg::PIN_W-1:0]              pad_out,
  output logic      [gpc_pkg::PIN_W-1:0]              pad_oe,
  output logic      [gpc_pkg::PIN_W-1:0]              pad_pu,
  output logic      [gpc_pkg::PIN_W-1:0]              pad_pd,
  output logic      [gpc_pkg::PIN_W-1:0]              pin_in,
  input  wire logic [gpc_pkg::FN_N*gpc_pkg::PIN_W-1:0] fn_out,
  input  wire logic [gpc_pkg::FN_N*gpc_pkg::PIN_W-1:0] fn_oe
);

  //==========================================================================
  // address decode
  logic       hit_data;  // data register
  logic       hit_oe;    // output enable
  logic       hit_od;    // open drain
  logic       hit_pup;   // pull-up
  logic       hit_pdn;   // pull-down
  logic       hit_ie;    // input enable
  logic [2:0] hit_fn;    // function registers one to three

  assign hit_data  = (addr == gpc_pkg::OFS_DATA);
  assign hit_oe    = (addr == gpc_pkg::OFS_OE);
  assign hit_fn[0] = (addr == gpc_pkg::OFS_FN1);
  assign hit_fn[1] = (addr == gpc_pkg::OFS_FN2);
  assign hit_fn[2] = (addr == gpc_pkg::OFS_FN3);
  assign hit_od    = (addr == gpc_pkg::OFS_OD);
  assign hit_pup   = (addr == gpc_pkg::OFS_PUP);
  assign hit_pdn   = (addr == gpc_pkg::OFS_PDN);
  assign hit_ie    = (addr == gpc_pkg::OFS_IE);

  //==========================================================================
  // register storage
  logic [7:0] pin_data_q;          // output latch
  logic [7:0] output_enable_bits;  // driver enables
  logic [7:0] open_drain_bits;     // open drain selects
  logic [7:0] pullup_bits;         // pull-up enables
  logic [7:0] pulldown_bits;       // pull-down enables
  logic [7:0] input_enable_bits;   // input path enables
  logic [7:0] function_select_bits [gpc_pkg::FN_N];

  // port data latch drives the pins
  gpc_reg8 #(.RST(gpc_pkg::RST_DATA)) u_data (
    .clk(clk), .nrst(nrst), .wr_en(wr & hit_data),
    .wdata(wdata[7:0]), .value_q(pin_data_q));
  gpc_reg8 #(.RST(gpc_pkg::RST_OE)) u_oe (
    .clk(clk), .nrst(nrst), .wr_en(wr & hit_oe),
    .wdata(wdata[7:0]), .value_q(output_enable_bits));
  gpc_reg8 #(.RST(gpc_pkg::RST_OD)) u_od (
    .clk(clk), .nrst(nrst), .wr_en(wr & hit_od),
    .wdata(wdata[7:0]), .value_q(open_drain_bits));
  gpc_reg8 #(.RST(gpc_pkg::RST_PUP)) u_pup (
    .clk(clk), .nrst(nrst), .wr_en(wr & hit_pup),
    .wdata(wdata[7:0]), .value_q(pullup_bits));
  gpc_reg8 #(.RST(gpc_pkg::RST_PDN)) u_pdn (
    .clk(clk), .nrst(nrst), .wr_en(wr & hit_pdn),
    .wdata(wdata[7:0]), .value_q(pulldown_bits));
  gpc_reg8 #(.RST(gpc_pkg::RST_IE)) u_ie (
    .clk(clk), .nrst(nrst), .wr_en(wr & hit_ie),
    .wdata(wdata[7:0]), .value_q(input_enable_bits));

  // one register per alternate function
  genvar f;
  generate
    for (f = 0; f < gpc_pkg::FN_N; f++) begin : g_fn
      gpc_reg8 #(.RST(gpc_pkg::RST_FN)) u_fn (
        .clk(clk), .nrst(nrst), .wr_en(wr & hit_fn[f]),
        .wdata(wdata[7:0]), .value_q(function_select_bits[f]));
    end
  endgenerate

  //==========================================================================
  // pin muxes, one per pin
  genvar p;
  generate
    for (p = 0; p < gpc_pkg::PIN_W; p++) begin : g_pin
      logic [gpc_pkg::FN_N-1:0] sel;  // function selects for this pin
      logic [gpc_pkg::FN_N-1:0] fo;   // function levels
      logic [gpc_pkg::FN_N-1:0] fe;   // function enables
      for (f = 0; f < gpc_pkg::FN_N; f++) begin : g_f
        assign sel[f] = function_select_bits[f][p];
        assign fo[f]  = fn_out[f*gpc_pkg::PIN_W+p];
        assign fe[f]  = fn_oe[f*gpc_pkg::PIN_W+p];
      end
      gpc_pin_mux u_mux (
        .port_data(pin_data_q[p]),
        .port_oe  (output_enable_bits[p]),
        .od_sel   (open_drain_bits[p]),
        .ie       (input_enable_bits[p]),
        .fn_sel   (sel),
        .fn_out   (fo),
        .fn_oe    (fe),
        .pad_in   (pad_in[p]),
        .pad_out  (pad_out[p]),
        .pad_oe   (pad_oe[p]),
        .pin_in   (pin_in[p])
      );
    end
  endgenerate

  // resistor enables pass straight to the pad cells
  assign pad_pu = pullup_bits;
  assign pad_pd = pulldown_bits;

  //==========================================================================
  // read mux; data read returns the gated pin level, not the latch
  logic [7:0] rd_byte;  // selected low byte
  assign rd_byte =
      hit_data  ? pin_in :
      hit_oe    ? output_enable_bits :
      hit_fn[0] ? function_select_bits[0] :
      hit_fn[1] ? function_select_bits[1] :
      hit_fn[2] ? function_select_bits[2] :
      hit_od    ? open_drain_bits :
      hit_pup   ? pullup_bits :
      hit_pdn   ? pulldown_bits :
      hit_ie    ? input_enable_bits : 8'h00;   // unmapped reads zero

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      rdata <= {24'h00_0000, rd_byte};
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule

// file: include/gpc_pkg.sv
//==========================================================================
// Overview of operation
// - per-pin output enable bits seven to zero
// - input enable kept separate from output control
// - per-pin input enable bits gate input path
// - one function register per alternate function
// - open-drain bit disables driver when data high
// - per-pin pull-up enable bits
// - per-pin pull-down enable bits
// - data register drives outputs, reads gated pin levels
package gpc_pkg;

  //==========================================================================
  // geometry
  localparam int          PIN_W   = 8;  // pins in the port
  localparam int          FN_N    = 3;  // alternate function registers
  localparam int          ADDR_W  = 8;  // byte address width
  localparam int          DATA_W  = 32; // bus data width

  //==========================================================================
  // register byte offsets within the port window
  localparam logic [7:0]  OFS_DATA = 8'h00;
  localparam logic [7:0]  OFS_OE   = 8'h04;
  localparam logic [7:0]  OFS_FN1  = 8'h08;
  localparam logic [7:0]  OFS_FN2  = 8'h0C;
  localparam logic [7:0]  OFS_FN3  = 8'h10;
  localparam logic [7:0]  OFS_OD   = 8'h28;
  localparam logic [7:0]  OFS_PUP  = 8'h2C;
  localparam logic [7:0]  OFS_PDN  = 8'h30;
  localparam logic [7:0]  OFS_IE   = 8'h38;

  //==========================================================================
  // reset values, port specific, neutral defaults
  localparam logic [7:0]  RST_DATA = 8'h00;
  localparam logic [7:0]  RST_OE   = 8'h00;
  localparam logic [7:0]  RST_FN   = 8'h00;
  localparam logic [7:0]  RST_OD   = 8'h00;
  localparam logic [7:0]  RST_PUP  = 8'h00;
  localparam logic [7:0]  RST_PDN  = 8'h00;
  localparam logic [7:0]  RST_IE   = 8'h00;

endpackage

// file: core/gpc_reg8.sv
`timescale 1ns/1ps
//==========================================================================
// one 8-bit software register with write strobe
module gpc_reg8 #(
  parameter logic [7:0] RST = 8'h00  // value after reset
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] value_q
);

  // only the low byte is kept; upper write bits fall away
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      value_q <= RST;
    end else if (wr_en) begin
      value_q <= wdata;
    end
  end

endmodule

// file: core/gpc_pin_mux.sv
`timescale 1ns/1ps
//==========================================================================
// per-pin output selection and driver control, purely combinational
module gpc_pin_mux (
  input  wire logic                         port_data,
  input  wire logic                         port_oe,
  input  wire logic                         od_sel,
  input  wire logic                         ie,
  input  wire logic [gpc_pkg::FN_N-1:0]     fn_sel,
  input  wire logic [gpc_pkg::FN_N-1:0]     fn_out,
  input  wire logic [gpc_pkg::FN_N-1:0]     fn_oe,
  input  wire logic                         pad_in,
  output logic                              pad_out,
  output logic                              pad_oe,
  output logic                              pin_in
);

  logic any_fn;   // some function owns the pin
  logic data_mux; // selected output level
  logic oe_mux;   // selected driver enable

  // or-select: legal only while one function bit is set per pin
  assign any_fn   = |fn_sel;
  assign data_mux = any_fn ? |(fn_sel & fn_out) : port_data;
  assign oe_mux   = any_fn ? |(fn_sel & fn_oe)  : port_oe;
  // pseudo open drain: driver off whenever the level is high
  assign pad_oe   = oe_mux & ~(od_sel & data_mux);
  assign pad_out  = data_mux;
  // input path gated only by its own enable, not the output one
  assign pin_in   = ie & pad_in;

endmodule

// file: dv/gpc_port_assertions.sv
`timescale 1ns/1ps
//==============================================
// bus and pin relations seen at the port pins
module gpc_port_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [7:0]  pad_in,
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pad_pu
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // upper three bytes never carry anything
  upper_zero_a: assert property (rdata[31:8] == 24'h0)
    else $error("rdata upper bits set");
  // read bus idles at zero, so a stale word cannot hide
  idle_zero_a: assert property (!rd |=> rdata == 32'h0)
    else $error("rdata not idle");
  pin_gate_a: assert property ((pin_in & ~pad_in) == 8'h00)
    else $error("pin_in set on a low pad");
  pu_write_a: assert property (wr && addr == gpc_pkg::OFS_PUP |=>
    pad_pu == $past(wdata[7:0])) else $error("pull-up not written");
  pu_hold_a: assert property (!(wr && addr == gpc_pkg::OFS_PUP) |=>
    $stable(pad_pu)) else $error("pull-up moved");
  pu_read_a: assert property (rd && addr == gpc_pkg::OFS_PUP |=>
    rdata[7:0] == $past(pad_pu)) else $error("pull-up readback");
  data_read_a: assert property (rd && addr == gpc_pkg::OFS_DATA |=>
    rdata[7:0] == $past(pin_in)) else $error("data read wrong");
  unmapped_a: assert property (rd && addr == 8'h14 |=>
    rdata == 32'h0) else $error("unmapped read nonzero");
endmodule

bind gpc_port gpc_port_chk chk_u (.clk, .nrst, .addr, .wdata, .wr, .rd,
  .rdata, .pad_in, .pin_in, .pad_pu);

// file: dv/gpc_pad_model.sv
`timescale 1ns/1ps
//==============================================
// pins outside the chip: driver, else pull, else drifting level
module gpc_pad_model (
  input  wire logic       clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pu,
  input  wire logic [7:0] pad_pd,
  output logic      [7:0] pad_in
);
  logic [7:0] float_q;  // undriven pins without a pull flip every cycle
  initial float_q = 8'h5A;
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  // pull-up beats pull-down when both are on
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & pad_pu)
                | (~pad_oe & ~pad_pu & ~pad_pd & float_q);
endmodule

// file: dv/gpc_port_tb.sv
`timescale 1ns/1ps
//==============================================
// random register setups with corner cases first
module gpc_port_tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [23:0] fn_out = 24'h0;
  logic [23:0] fn_oe = 24'h0;
  logic [31:0] rdata;
  logic [7:0]  pad_in, pad_out, pad_oe, pad_pu, pad_pd, pin_in;
  logic [7:0]  oe, dat, od, ie, pu, sel, eo, ee, ei;  // setup, expects
  int          n_fail = 0;
  int          checked = 0;
  logic [7:0]  ofs [8] = '{gpc_pkg::OFS_OE, gpc_pkg::OFS_FN1,
    gpc_pkg::OFS_FN2, gpc_pkg::OFS_FN3, gpc_pkg::OFS_OD,
    gpc_pkg::OFS_PUP, gpc_pkg::OFS_PDN, gpc_pkg::OFS_IE};
  always #12.5 clk = ~clk;
  gpc_port dut_u (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .pad_in,
    .pad_out, .pad_oe, .pad_pu, .pad_pd, .pin_in, .fn_out, .fn_oe);
  gpc_pad_model pads_u (.clk, .pad_out, .pad_oe, .pad_pu, .pad_pd,
    .pad_in);
  // per-bit select: s picks a, else b
  function automatic logic [7:0] drv(input logic [7:0] s, a, b);
    return (s & a) | (~s & b);
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // junk in the upper bits must be dropped
  task automatic wreg(input logic [7:0] a, d);
    logic [31:0] r;
    r = $urandom;
    wr <= 1'b1;
    addr <= a;
    wdata <= {r[23:0], d};
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  initial begin
    void'($urandom(96));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (ofs[i]) rreg(ofs[i], 32'h0);
    rreg(8'h14, 32'h0);
    foreach (ofs[i]) begin
      dat = $urandom;
      wreg(ofs[i], dat);
      rreg(ofs[i], {24'h0, dat});
    end
    // first four passes push-pull, first eight port only; later ones random
    for (int k = 0; k < 24; k++) begin
      oe = $urandom;
      dat = $urandom;
      ie = $urandom;
      pu = $urandom;
      od = (k < 4) ? 8'h00 : 8'($urandom);
      sel = (k < 8) ? 8'h00 : 8'($urandom);
      fn_out <= 24'($urandom);
      fn_oe <= 24'($urandom);
      foreach (ofs[i]) wreg(ofs[i], drv({8{i == 0}}, oe,
        drv({8{i == 4}}, od, drv({8{i == 5}}, pu, drv({8{i == 6}}, ~pu,
        drv({8{i == 7}}, ie, (i == k % 3 + 1) ? sel : 8'h00))))));
      wreg(gpc_pkg::OFS_DATA, dat);
      eo = drv(sel, fn_out[(k % 3) * 8 +: 8], dat);
      ee = drv(sel, fn_oe[(k % 3) * 8 +: 8], oe) & ~(od & eo);
      ei = drv(ee, eo, pu) & ie;
      @(negedge clk);
      chk(pad_out, eo);
      chk(pad_oe, ee);
      chk(pin_in, ei);
      chk({pad_pu, pad_pd}, {pu, ~pu});
      @(posedge clk);
      rreg(gpc_pkg::OFS_DATA, ei);
    end
    wrap_up();
  end
endmodule
